// ==== baud_pkg.sv ====
// baud_pkg: register map, field positions, reset values and divide factors
// for the rate divider block; assumes a 32-bit apb register bus.
`default_nettype none
package baud_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] tx_control_status_off = 8'h00;
  localparam logic [7:0] rx_control_status_off = 8'h04;
  localparam logic [7:0] baud_control_off = 8'h08;
  localparam logic [7:0] divisor_high_off = 8'h0c;
  localparam logic [7:0] divisor_low_off = 8'h10;
  localparam logic [7:0] sampler_status_off = 8'h14;
  // field positions
  localparam int sync_mode_bit = 4;
  localparam int high_speed_select_bit = 2;
  localparam int port_enable_bit = 7;
  localparam int wide_divider_select_bit = 3;
  // writable masks (unimplemented bits read zero)
  localparam logic [7:0] tx_control_mask = 8'hfd;
  localparam logic [7:0] rx_control_mask = 8'hf8;
  localparam logic [7:0] baud_control_mask = 8'h9b;
  // reset values
  localparam logic [7:0] tx_control_reset = 8'h00;
  localparam logic [7:0] rx_control_reset = 8'h00;
  localparam logic [7:0] baud_control_reset = 8'h00;
  localparam logic [7:0] divisor_reset = 8'h00;
  // prescale factors applied to (divisor + 1)
  localparam logic [6:0] factor_64 = 7'd64;
  localparam logic [6:0] factor_16 = 7'd16;
  localparam logic [6:0] factor_4 = 7'd4;
  // number of samples taken from the bit centre onward for the majority vote
  localparam int vote_samples = 3;
endpackage
`default_nettype wire

// ==== uart_baud_rate_generator.sv ====
// uart_baud_rate_generator: apb register slave, free-running rate divider
// and three-sample majority sampler for the serial input pin.
// assumes a 20 mhz pclk and an asynchronous serial_input_pin.
//
// Design decisions made here: the APB register port and the register offsets.
`default_nettype none

module uart_baud_rate_generator
  import baud_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_input_pin,
  output logic bit_tick,
  output logic sample_tick,
  output logic rx_level
);

  logic [7:0] tx_control_reg, tx_control_next;
  logic [7:0] rx_control_reg, rx_control_next;
  logic [7:0] baud_control_reg, baud_control_next;
  logic [7:0] divisor_high_byte_reg, divisor_high_byte_next;
  logic [7:0] divisor_low_byte_reg, divisor_low_byte_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [21:0] count_reg, count_next;
  logic [1:0] phase_reg, phase_next;
  logic [2:0] votes_reg, votes_next;
  logic rx_level_reg, rx_level_next;
  logic bit_tick_reg, bit_tick_next;
  logic sample_tick_reg, sample_tick_next;
  logic pin_meta_reg, pin_sync_reg;
  logic read_loaded_reg, read_loaded_next;

  logic access, wr, rd, addr_ok, divisor_write;
  logic sync_mode, wide_sel, high_sel;
  logic [15:0] divisor;
  logic [6:0] factor;
  logic [21:0] period;
  logic [21:0] sample_point;

  // majority of three samples
  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    return a == tx_control_status_off || a == rx_control_status_off ||
      a == baud_control_off || a == divisor_high_off ||
      a == divisor_low_off || a == sampler_status_off;
  endfunction

  assign access = psel & penable & clk_en;
  assign wr = access & pwrite;
  // read data is loaded from the setup phase so it stands at the ready edge
  assign rd = psel & ~pwrite & ~read_loaded_reg;
  assign addr_ok = known_addr(paddr);
  assign divisor_write = wr & (paddr == divisor_high_off || paddr == divisor_low_off);

  assign sync_mode = tx_control_reg[sync_mode_bit];
  assign wide_sel = baud_control_reg[wide_divider_select_bit];
  assign high_sel = tx_control_reg[high_speed_select_bit];

  always_comb begin
    divisor = wide_sel ? {divisor_high_byte_reg, divisor_low_byte_reg}
                       : {8'h00, divisor_low_byte_reg};
    if (sync_mode) begin
      factor = factor_4;
    end else if (!high_sel) begin
      factor = wide_sel ? factor_16 : factor_64;
    end else begin
      factor = wide_sel ? factor_4 : factor_16;
    end
    period = 22'(({6'h00, divisor} + 22'd1) * {15'h0000, factor});
    sample_point = period >> 1;
  end

  // register file
  always_comb begin
    tx_control_next = tx_control_reg;
    rx_control_next = rx_control_reg;
    baud_control_next = baud_control_reg;
    divisor_high_byte_next = divisor_high_byte_reg;
    divisor_low_byte_next = divisor_low_byte_reg;
    prdata_next = prdata_reg;
    read_loaded_next = psel & ~pwrite & ~(penable & pready);
    if (wr) begin
      unique case (paddr)
        tx_control_status_off: tx_control_next = pwdata[7:0] & tx_control_mask;
        rx_control_status_off: rx_control_next = pwdata[7:0] & rx_control_mask;
        baud_control_off: baud_control_next = pwdata[7:0] & baud_control_mask;
        divisor_high_off: divisor_high_byte_next = pwdata[7:0];
        divisor_low_off: divisor_low_byte_next = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        tx_control_status_off: prdata_next = {24'h000000, tx_control_reg};
        rx_control_status_off: prdata_next = {24'h000000, rx_control_reg};
        baud_control_off: prdata_next = {24'h000000, baud_control_reg};
        divisor_high_off: prdata_next = {24'h000000, divisor_high_byte_reg};
        divisor_low_off: prdata_next = {24'h000000, divisor_low_byte_reg};
        sampler_status_off: prdata_next = {30'h00000000, pin_sync_reg, rx_level_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  // divider and sampler
  always_comb begin
    count_next = count_reg;
    phase_next = phase_reg;
    votes_next = votes_reg;
    rx_level_next = rx_level_reg;
    bit_tick_next = 1'b0;
    sample_tick_next = 1'b0;
    if (!rx_control_reg[port_enable_bit] || divisor_write) begin
      count_next = 22'd0;
      phase_next = 2'd0;
    end else if (count_reg >= period - 22'd1) begin
      count_next = 22'd0;
      bit_tick_next = 1'b1;
      phase_next = 2'd0;
    end else begin
      count_next = count_reg + 22'd1;
      // three samples starting at the bit centre, one cycle apart
      if (count_reg + 22'd1 >= sample_point && phase_reg != 2'(vote_samples)) begin
        votes_next = {votes_reg[1:0], pin_sync_reg};
        phase_next = phase_reg + 2'd1;
        if (phase_reg == 2'(vote_samples - 1)) begin
          rx_level_next = majority({votes_reg[1:0], pin_sync_reg});
          sample_tick_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_control_reg <= tx_control_reset;
      rx_control_reg <= rx_control_reset;
      baud_control_reg <= baud_control_reset;
      divisor_high_byte_reg <= divisor_reset;
      divisor_low_byte_reg <= divisor_reset;
      prdata_reg <= 32'h00000000;
      read_loaded_reg <= 1'b0;
      count_reg <= 22'd0;
      phase_reg <= 2'd0;
      votes_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      bit_tick_reg <= 1'b0;
      sample_tick_reg <= 1'b0;
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else if (clk_en) begin
      tx_control_reg <= tx_control_next;
      rx_control_reg <= rx_control_next;
      baud_control_reg <= baud_control_next;
      divisor_high_byte_reg <= divisor_high_byte_next;
      divisor_low_byte_reg <= divisor_low_byte_next;
      prdata_reg <= prdata_next;
      read_loaded_reg <= read_loaded_next;
      count_reg <= count_next;
      phase_reg <= phase_next;
      votes_reg <= votes_next;
      rx_level_reg <= rx_level_next;
      bit_tick_reg <= bit_tick_next;
      sample_tick_reg <= sample_tick_next;
      pin_meta_reg <= serial_input_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // writes wait only for clk_en; a read also waits until its data has been loaded
  assign pready = clk_en & (pwrite | read_loaded_reg);
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_reg;
  assign bit_tick = bit_tick_reg;
  assign sample_tick = sample_tick_reg;
  assign rx_level = rx_level_reg;

endmodule
`default_nettype wire

// ==== baud_asserts.sv ====
// checker: bus, divider tick and sampler relations at the block's ports
// assumes one pclk domain and the register map of baud_pkg
`default_nettype none
module baud_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_input_pin,
  input wire logic bit_tick,
  input wire logic sample_tick,
  input wire logic rx_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd, bad;
  assign rd = psel && penable && !pwrite && pready;
  assign bad = paddr > 8'h14 || paddr[1:0] != 2'b00;
  ready_follows_a: assert property (pready |-> clk_en) else $error("pready without enable");
  bad_addr_err_a: assert property (psel && penable && bad |-> pslverr)
    else $error("no slverr");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("stray slverr");
  read_zero_a: assert property (rd && bad |-> prdata == 32'h0) else $error("unmapped data");
  rdata_holds_a: assert property (!(psel && !pwrite && clk_en) |=> $stable(prdata))
    else $error("prdata moved");
  tick_gap_a: assert property (bit_tick |=> !bit_tick [*3])
    else $error("ticks too close");
  sample_pulse_a: assert property (sample_tick |=> !sample_tick) else $error("long sample");
  vote_level_a: assert property (
    (clk_en && $stable(serial_input_pin)) [*8] ##0 sample_tick
    |-> rx_level == serial_input_pin) else $error("vote wrong");
endmodule
bind uart_baud_rate_generator baud_asserts i_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .serial_input_pin, .bit_tick, .sample_tick,
  .rx_level);
`default_nettype wire

// ==== testbench.sv ====
// bench: register access, divide factors, counter clear and majority vote
// assumes the block answers apb with registered read data
`default_nettype none
module testbench
  import baud_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pin = 1;
  logic [7:0] paddr = 8'h00, hi;
  logic [31:0] pwdata = 32'h0, prdata, got, r, seed = 32'h17c39bf7;
  logic pready, pslverr, bit_tick, sample_tick, rx_level, err;
  int mismatches = 0, comparisons = 0, cyc = 0, cnt, n, f;
  logic [31:0] exp_q[$];
  string what;
  event seen;
  uart_baud_rate_generator i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_input_pin(pin), .bit_tick,
    .sample_tick, .rx_level);
  always #25 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w) begin
      got = prdata;
      -> seen;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tick_gap(output int k);
    do @(posedge pclk); while (bit_tick !== 1'b1);
    k = 0;
    do begin @(posedge pclk); k++; end while (bit_tick !== 1'b1);
  endtask
  always @(seen) begin
    comparisons++;
    if (got !== exp_q[0]) begin
      mismatches++;
      $display("wrong value %0s expected %0h seen %0h", what, exp_q[0], got);
    end
    void'(exp_q.pop_front());
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin mismatches++; summarize(); end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    what = "registers";
    rd(tx_control_status_off, {24'h0, tx_control_reset});
    // wait states while the clock enable is low
    fork begin repeat (2) @(posedge pclk); clk_en <= 1'b0; repeat (3) @(posedge pclk);
      clk_en <= 1'b1; end join_none
    apb(1'b1, baud_control_off, 32'hff);
    rd(baud_control_off, {24'h0, baud_control_mask});
    rd(8'h18, 32'h0);
    @(posedge pclk);
    exp_q.push_back(32'h1);
    got = {31'h0, err};
    -> seen;
    apb(1'b1, rx_control_status_off, 32'h80);
    $display("test registers done");
    what = "period";
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      hi = i[1] ? 8'h01 : r[15:8];
      n = i[1] ? {hi, 4'h0, r[3:0]} : {4'h0, r[3:0]};
      f = i[2] ? 4 : i[1] ? (i[0] ? 4 : 16) : (i[0] ? 16 : 64);
      apb(1'b1, tx_control_status_off, {27'h0, i[2], 1'b0, i[0], 2'b0});
      apb(1'b1, baud_control_off, {28'h0, i[1], 3'h0});
      apb(1'b1, divisor_high_off, {24'h0, hi});
      apb(1'b1, divisor_low_off, {28'h0, r[3:0]});
      exp_q.push_back(f * (n + 1));
      tick_gap(cnt);
      tick_gap(cnt);
      got = cnt;
      -> seen;
      $display("test mode %0d done", i);
    end
    apb(1'b1, tx_control_status_off, 32'h0);
    apb(1'b1, baud_control_off, 32'h0);
    apb(1'b1, divisor_low_off, 32'h0f); // reprogram divisor
    tick_gap(cnt);
    what = "restart";
    exp_q.push_back(1);
    fork
      begin cnt = 0; do begin @(posedge pclk); cnt++; end while (bit_tick !== 1'b1); end
      begin repeat (500) @(posedge pclk); apb(1'b1, divisor_low_off, 32'h0f); end
    join
    got = {31'h0, cnt > 1024};
    -> seen;
    what = "glitch";
    exp_q.push_back(0);
    cnt = 0;
    repeat (400) begin
      @(posedge pclk);
      pin <= 1'b0;
      repeat (5) begin @(posedge pclk); pin <= 1'b1; cnt += (rx_level !== 1'b1); end
    end
    got = cnt;
    -> seen;
    what = "status";
    pin <= 1'b0;
    repeat (2100) @(posedge pclk);
    rd(sampler_status_off, 32'h0);
    pin <= 1'b1;
    repeat (2100) @(posedge pclk);
    rd(sampler_status_off, 32'h3);
    $display("test sampling done");
    summarize();
  end
endmodule
`default_nettype wire
